//--- logic/rtc_calendar_control.sv
// Behaviour
// - Drift trim is signed ten-bit, zero no correction
// - Positive trim adds pulses each minute, max 511
// - Negative trim removes pulses each minute, max 512
// - Unit runs only while enable bit set
// - Halt-in-idle stops unit during processor idle
// - Enable bit writable only while unlock bit one
// - Pin driven only while output enable set
// - Unlock bit settable only after key sequence
// - Half-second flag read-only, cleared by seconds write
// - Running flag undefined with internal oscillator selected
// - Control register reset only at power-on
// - Unimplemented bits read zero, writes dropped
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
module rtc_calendar_control #(
	parameter int HALF_PULSES     = rtc_ctrl_pkg::HALF_PULSES_DEF,
	parameter int RUN_TIMEOUT_CYC = rtc_ctrl_pkg::RUN_TIMEOUT_CYC
) (
	// Clock and power-on reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Wishbone slave
	input  wire rtc_ctrl_pkg::wb_req_s wb_i,
	output      rtc_ctrl_pkg::wb_rsp_s wb_o,
	// Time sources and system state
	input  wire logic [3:0]            src_clk_i,
	input  wire logic                  idle_i,
	input  wire logic                  alarm_i,
	// Output pin and status
	output      logic                  rtc_pin_o,
	output      logic                  rtc_pin_oe_o,
	output      logic                  unit_run_o,
	output      logic                  second_tick_o
);
	import rtc_ctrl_pkg::*;

	localparam int PRE_B = $clog2(HALF_PULSES) > CAL_W ? $clog2(HALF_PULSES) : CAL_W;
	localparam int PRE_W = PRE_B + 2;
	localparam int RUN_W = $clog2(RUN_TIMEOUT_CYC + 1);
	localparam logic signed [PRE_W-1:0] HALF_TOP  = PRE_W'(HALF_PULSES - 1);
	localparam logic signed [PRE_W-1:0] SYNC_FROM = PRE_W'(HALF_PULSES - SYNC_WINDOW);
	localparam logic [RUN_W-1:0]        RUN_MAX   = RUN_W'(RUN_TIMEOUT_CYC);

	logic [31:0]             ctrl_r;
	logic [31:0]             ctrl_nxt;
	unlock_e                 unl_r;
	logic                    ack_r;
	logic [31:0]             rdat_r;
	logic [3:0]              meta_r;
	logic [3:0]              sync_r;
	logic                    src_prev_r;
	logic signed [PRE_W-1:0] cnt_r;
	logic [SEC_W-1:0]        sec_r;
	logic                    half_r;
	logic [RUN_W-1:0]        idle_cnt_r;
	logic                    pin_r;
	logic                    tick_r;

	logic                    req;
	logic                    wr;
	logic                    wr_ctrl;
	logic                    wr_key;
	logic                    wr_time;
	logic                    run;
	logic                    src_now;
	logic                    src_edge;
	logic                    half_end;
	logic                    minute_end;
	logic                    clk_on;
	logic                    sync_flag;
	logic                    pin_sel;
	logic [31:0]             ctrl_rd;
	logic [6:0]              sec_wr;
	logic signed [PRE_W-1:0] cal_ext;

	// Bus decode
	assign req     = wb_i.cyc & wb_i.stb & ~ack_r;
	assign wr      = req & wb_i.we;
	assign wr_ctrl = wr & (wb_i.adr == CTRL_OFS);
	assign wr_key  = wr & (wb_i.adr == KEY_OFS) & (&wb_i.sel);
	assign wr_time = wr & (wb_i.adr == TIME_OFS) & wb_i.sel[1];
	assign sec_wr  = wb_i.dat[SEC_LSB +: SEC_W];

	// Run gating
	assign run = ctrl_r[ON_BIT] & ~(ctrl_r[HALT_BIT] & idle_i);

	// Control write with byte lanes and lock gating
	always_comb begin
		ctrl_nxt = ctrl_r;
		for (int b = 0; b < 4; b++) begin
			if (wb_i.sel[b]) begin
				ctrl_nxt[8*b +: 8] = wb_i.dat[8*b +: 8];
			end
		end
		ctrl_nxt = ctrl_nxt & CTRL_WMASK;
		if (!ctrl_r[WREN_BIT]) begin
			ctrl_nxt[ON_BIT] = ctrl_r[ON_BIT];
		end
		// Clearing the unlock bit is always allowed
		if (unl_r != UNL_OPEN && !ctrl_r[WREN_BIT]) begin
			ctrl_nxt[WREN_BIT] = 1'b0;
		end
	end

	// Only the power-on reset reaches this register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Two-key unlock sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unl_r <= UNL_IDLE;
		end else if (wr_key) begin
			case (unl_r)
				UNL_IDLE: unl_r <= (wb_i.dat == KEY_FIRST) ? UNL_HALF : UNL_IDLE;
				UNL_HALF: unl_r <= (wb_i.dat == KEY_SECOND) ? UNL_OPEN : UNL_IDLE;
				UNL_OPEN: unl_r <= (wb_i.dat == KEY_FIRST) ? UNL_HALF : UNL_IDLE;
				default:  unl_r <= UNL_IDLE;
			endcase
		end
	end

	// Source synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r     <= 4'h0;
			sync_r     <= 4'h0;
			src_prev_r <= 1'b0;
		end else begin
			meta_r     <= src_clk_i;
			sync_r     <= meta_r;
			src_prev_r <= src_now;
		end
	end

	assign src_now  = sync_r[ctrl_r[CLKSEL_LSB +: 2]];
	assign src_edge = src_now & ~src_prev_r;

	// Activity watchdog; also used for the internal oscillator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_r <= RUN_MAX;
		end else if (src_edge) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != RUN_MAX) begin
			idle_cnt_r <= idle_cnt_r + RUN_W'(1);
		end
	end

	assign clk_on = idle_cnt_r != RUN_MAX;

	// Prescaler with drift trim
	assign cal_ext    = PRE_W'($signed(ctrl_r[CAL_LSB +: CAL_W]));
	assign half_end   = run & src_edge & (cnt_r >= HALF_TOP);
	assign minute_end = half_end & half_r & (sec_r == SEC_LAST);

	// A negative start stretches the next half-second, a positive one shortens it
	always_ff @(posedge clk_i) begin
		if (rst_i || wr_time) begin
			cnt_r <= '0;
		end else if (minute_end) begin
			cnt_r <= cal_ext;
		end else if (half_end) begin
			cnt_r <= '0;
		end else if (run && src_edge) begin
			cnt_r <= cnt_r + PRE_W'(1);
		end
	end

	// Seconds and half-second; a seconds write wins over a rollover
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_r  <= '0;
			half_r <= 1'b0;
		end else if (wr_time) begin
			sec_r  <= (sec_wr > SEC_LAST) ? '0 : sec_wr;
			half_r <= 1'b0;
		end else if (half_end) begin
			half_r <= ~half_r;
			if (half_r) begin
				sec_r <= (sec_r == SEC_LAST) ? '0 : sec_r + SEC_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= half_end & half_r & ~wr_time;
		end
	end

	assign sync_flag = run & half_r & (cnt_r >= SYNC_FROM);

	// Output pin
	always_comb begin
		case (pin_sel_e'(ctrl_r[OUTSEL_LSB +: 2]))
			PIN_ALARM:   pin_sel = alarm_i;
			PIN_SECONDS: pin_sel = half_r;
			PIN_SOURCE:  pin_sel = src_now;
			default:     pin_sel = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= ctrl_r[OE_BIT] & pin_sel;
		end
	end

	// Read path
	always_comb begin
		ctrl_rd              = ctrl_r & CTRL_WMASK;
		ctrl_rd[CLKON_BIT]   = clk_on;
		ctrl_rd[SYNC_BIT]    = sync_flag;
		ctrl_rd[HALF_BIT]    = half_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r  <= req;
			rdat_r <= 32'h0000_0000;
			if (req && !wb_i.we) begin
				case (wb_i.adr)
					CTRL_OFS: rdat_r <= ctrl_rd;
					KEY_OFS:  rdat_r <= {31'h0, unl_r == UNL_OPEN};
					TIME_OFS: rdat_r <= {17'h0, sec_r, 8'h00};
					default:  rdat_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_o.ack      = ack_r;
	assign wb_o.dat      = rdat_r;
	assign rtc_pin_o     = pin_r;
	assign rtc_pin_oe_o  = ctrl_r[OE_BIT];
	assign unit_run_o    = run;
	assign second_tick_o = tick_r;

	// Checks
	sequence s_half_done;
		half_end && half_r && !wr_time;
	endsequence

	sequence s_minute_done;
		s_half_done ##0 (sec_r == SEC_LAST);
	endsequence

	property p_trim_load;
		@(posedge clk_i) disable iff (rst_i)
		s_minute_done |=> (cnt_r == $past(cal_ext)) && (sec_r == '0);
	endproperty
	a_trim_load: assert property (p_trim_load) else $error("trim not loaded at minute");

	property p_sec_step;
		@(posedge clk_i) disable iff (rst_i)
		s_half_done ##0 (sec_r != SEC_LAST) |=> sec_r == $past(sec_r) + SEC_W'(1) ##1 !tick_r;
	endproperty
	a_sec_step: assert property (p_sec_step) else $error("seconds did not advance");

	property p_on_locked;
		@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !ctrl_r[WREN_BIT] |=> $stable(ctrl_r[ON_BIT]);
	endproperty
	a_on_locked: assert property (p_on_locked) else $error("enable changed while locked");

	property p_unlock_gate;
		@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && unl_r != UNL_OPEN && !ctrl_r[WREN_BIT] |=> !ctrl_r[WREN_BIT];
	endproperty
	a_unlock_gate: assert property (p_unlock_gate) else $error("unlock set without keys");

	property p_half_clear;
		@(posedge clk_i) disable iff (rst_i)
		wr_time |=> !half_r && cnt_r == '0;
	endproperty
	a_half_clear: assert property (p_half_clear) else $error("half flag not cleared");

	property p_pin_off;
		@(posedge clk_i) disable iff (rst_i)
		!ctrl_r[OE_BIT] [*2] |-> !rtc_pin_o && !rtc_pin_oe_o;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

	property p_halt;
		@(posedge clk_i) disable iff (rst_i)
		(!ctrl_r[ON_BIT] || (ctrl_r[HALT_BIT] && idle_i)) && !wr_time
			|=> $stable(cnt_r) && $stable(sec_r);
	endproperty
	a_halt: assert property (p_halt) else $error("unit ran while halted");

	property p_unimp_zero;
		@(posedge clk_i) disable iff (rst_i)
		req && !wb_i.we && wb_i.adr == CTRL_OFS |=> ack_r && (wb_o.dat & CTRL_UNIMP) == 32'h0;
	endproperty
	a_unimp_zero: assert property (p_unimp_zero) else $error("unimplemented bits read set");

	property p_por_clear;
		@(posedge clk_i)
		rst_i |=> ctrl_r == CTRL_RESET && !rtc_pin_oe_o && !unit_run_o;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("control not cleared at reset");

endmodule

//--- shared/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;

	// Register byte offsets
	localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] KEY_OFS  = 32'h0000_0004;
	localparam logic [31:0] TIME_OFS = 32'h0000_0008;

	// Control register fields
	localparam int CAL_LSB     = 16;
	localparam int CAL_W       = 10;
	localparam int ON_BIT      = 15;
	localparam int HALT_BIT    = 13;
	localparam int CLKSEL_LSB  = 9;
	localparam int OUTSEL_LSB  = 7;
	localparam int CLKON_BIT   = 6;
	localparam int WREN_BIT    = 3;
	localparam int SYNC_BIT    = 2;
	localparam int HALF_BIT    = 1;
	localparam int OE_BIT      = 0;
	localparam logic [31:0] CTRL_WMASK = 32'h03FF_A789;
	localparam logic [31:0] CTRL_UNIMP = 32'hFC00_5800;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Time register seconds field
	localparam int SEC_LSB = 8;
	localparam int SEC_W   = 7;
	localparam logic [6:0] SEC_LAST = 7'h3B;

	// Unlock keys, values arbitrary
	localparam logic [31:0] KEY_FIRST  = 32'h0000_5A5A;
	localparam logic [31:0] KEY_SECOND = 32'h0000_A5A5;

	// Timing
	localparam int HALF_PULSES_DEF = 16384;
	localparam int SYNC_WINDOW     = 32;
	localparam int CLK_MHZ         = 50;
	localparam int RUN_TIMEOUT_US  = 100;
	localparam int RUN_TIMEOUT_CYC = RUN_TIMEOUT_US * CLK_MHZ;

	typedef enum logic [1:0] {
		PIN_ALARM,
		PIN_SECONDS,
		PIN_SOURCE,
		PIN_NONE
	} pin_sel_e;

	typedef enum logic [1:0] {
		UNL_IDLE,
		UNL_HALF,
		UNL_OPEN
	} unlock_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

endpackage

//--- verification/rtc_calendar_control_tb.sv
module rtc_calendar_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_ctrl_pkg::*;

	localparam int          HP      = 40;
	localparam int          SRC_DIV = 8; // Source model period in cycles
	localparam logic [31:0] NO_RUN  = 32'hFFFF_FFBF;

	logic        clk_i     = 1'b0;
	logic        rst_i     = 1'b1;
	logic        idle_i    = 1'b0;
	logic        alarm_req = 1'b0;
	wb_req_s     wb_req    = '0;
	wb_rsp_s     wb_rsp;
	logic [3:0]  src_clk;
	logic        alarm;
	logic        rtc_pin;
	logic        rtc_pin_oe;
	logic        unit_run;
	logic        second_tick;
	int          mismatches  = 0;
	int          check_count = 0;
	int          seed        = 71;
	int          g;
	logic [31:0] q;
	logic [31:0] v;
	logic [9:0]  trims [4];

	always #10 clk_i = ~clk_i;

	rtc_calendar_control #(.HALF_PULSES(HP), .RUN_TIMEOUT_CYC(50)) rtc_calendar_control_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
		.src_clk_i(src_clk), .idle_i(idle_i), .alarm_i(alarm),
		.rtc_pin_o(rtc_pin), .rtc_pin_oe_o(rtc_pin_oe),
		.unit_run_o(unit_run), .second_tick_o(second_tick)
	);

	rtc_source_model rtc_source_model_inst (
		.clk_i(clk_i), .rst_i(rst_i), .alarm_req_i(alarm_req),
		.src_clk_o(src_clk), .alarm_o(alarm)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		// No cycle count assumed; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(q & m, exp & m);
	endtask

	task automatic unlock();
		xfer(1'b1, KEY_OFS, KEY_FIRST);
		xfer(1'b1, KEY_OFS, KEY_SECOND);
	endtask

	// Cycles from one seconds tick to the next
	task automatic gap(output int c);
		do @(posedge clk_i); while (second_tick !== 1'b1);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (second_tick !== 1'b1);
	endtask

	// Tick gap after a minute wrap: one trimmed half-second, one plain
	function automatic int exp_gap(input logic [9:0] trim);
		exp_gap = SRC_DIV * (2 * HP - int'($signed(trim)));
	endfunction

	function automatic logic [31:0] ctl(input logic [9:0] trim, input logic on, input logic halt,
		input logic wren, input logic oe);
		ctl = 32'h0000_0000;
		ctl[CAL_LSB +: CAL_W] = trim;
		ctl[ON_BIT] = on;
		ctl[HALT_BIT] = halt;
		ctl[CLKSEL_LSB] = 1'b1;
		ctl[WREN_BIT] = wren;
		ctl[OE_BIT] = oe;
	endfunction

	task automatic final_report();
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Generous bound over the four minute-wrap runs
	initial begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		final_report();
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(CTRL_OFS, NO_RUN, CTRL_RESET);
		rd(32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_0000);
		repeat (6) begin
			v = $random(seed);
			xfer(1'b1, CTRL_OFS, v);
			rd(CTRL_OFS, NO_RUN, v & CTRL_WMASK & 32'hFFFF_7FF7);
		end
		rd(CTRL_OFS, 32'h0000_0040, 32'h0000_0040);
		// A wrong key in between must not open the sequence
		xfer(1'b1, KEY_OFS, KEY_FIRST);
		xfer(1'b1, KEY_OFS, 32'h0000_1234);
		xfer(1'b1, KEY_OFS, KEY_SECOND);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b1, 1'b0));
		rd(CTRL_OFS, 32'h0000_0008, 32'h0000_0000);
		unlock();
		rd(KEY_OFS, 32'h0000_0001, 32'h0000_0001);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b1, 1'b0));
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b1, 1'b0, 1'b1, 1'b0));
		rd(CTRL_OFS, 32'h0000_8008, 32'h0000_8008);
		chk(32'(unit_run), 32'h0000_0001);
		idle_i <= 1'b1;
		@(posedge clk_i);
		chk(32'(unit_run), 32'h0000_0001);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b1, 1'b1, 1'b1, 1'b0));
		chk(32'(unit_run), 32'h0000_0000);
		idle_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(unit_run), 32'h0000_0001);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b0, 1'b0));
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(CTRL_OFS, 32'h0000_8008, 32'h0000_0000);
		chk(32'(unit_run), 32'h0000_0000);
		alarm_req <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(32'({rtc_pin_oe, rtc_pin}), 32'h0000_0000);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b0, 1'b1));
		repeat (3) @(posedge clk_i);
		chk(32'({rtc_pin_oe, rtc_pin}), 32'h0000_0003);
		// Pin select three holds the pin low with the alarm up
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b0, 1'b1) | 32'h0000_0180);
		repeat (3) @(posedge clk_i);
		chk(32'({rtc_pin_oe, rtc_pin}), 32'h0000_0002);
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b0, 1'b1));
		alarm_req <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(32'({rtc_pin_oe, rtc_pin}), 32'h0000_0002);
		trims = '{10'h000, 10'h005, 10'h3FD, 10'h000};
		trims[3] = 10'($random(seed) % 12);
		unlock();
		// Enable only sticks once the unlock bit is already set
		xfer(1'b1, CTRL_OFS, ctl(10'h000, 1'b0, 1'b0, 1'b1, 1'b0));
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, CTRL_OFS, ctl(trims[i], 1'b1, 1'b0, 1'b1, 1'b0));
			xfer(1'b1, TIME_OFS, 32'({SEC_LAST}) << SEC_LSB);
			gap(g);
			chk(32'(g), 32'(exp_gap(trims[i])));
			gap(g);
			chk(32'(g), 32'(exp_gap(10'h000)));
		end
		do xfer(1'b0, CTRL_OFS, 32'h0000_0000); while (q[HALF_BIT] !== 1'b1);
		xfer(1'b1, TIME_OFS, 32'h0000_0700);
		rd(CTRL_OFS, 32'h0000_0002, 32'h0000_0000);
		rd(TIME_OFS, 32'hFFFF_FFFF, 32'h0000_0700);
		final_report();
	end
endmodule

//--- verification/rtc_source_model.sv
module rtc_source_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Alarm level requested by the bench
	input  wire logic       alarm_req_i,
	// Time sources and alarm
	output      logic [3:0] src_clk_o,
	output      logic       alarm_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] div_r;

	// Runs free; eight cycles a pulse, wide enough for the two-flop sync
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= 3'h0;
		end else begin
			div_r <= div_r + 3'h1;
		end
	end

	assign src_clk_o = {4{div_r[2]}};

	always_ff @(posedge clk_i) begin
		alarm_o <= alarm_req_i;
	end
endmodule
